// File: verilog/bsc_sram_ctrl.sv
// Control-input logic and storage of a pipelined burst SRAM.

// Notes on behaviour
// [R1] Address decodes one of 256K words.
// [R2] Capture needs a strobe and all selects.
// [R3] Low address bits load the burst counter.
// [R4] Lane selects write only with byte qualifier.
// [R5] Global write writes every lane.
// [R6] Controller drives byte qualifier low to write.
// [R7] Advance low increments the burst counter.
// [R8] Primary select high ignores processor strobe.
// [R9] High-active depth select joins device selection.
// [R10] Missing low depth select counts as active.
// [R11] Output enable low drives, high tri-states.
// [R12] First read clock after deselect stays undriven.
// [R13] Both strobes low: processor strobe wins.
// [R14] Read data comes from previous edge's address.
// [R15] Burst counter wraps within four words.
// [R16] Static input picks linear or interleaved order.
module bsc_sram_ctrl #(
    parameter int ADDR_W = bsc_pkg::ADDR_W,
    parameter int WORDS = bsc_pkg::WORDS,
    parameter int LANES = bsc_pkg::LANES,
    parameter int LANE_W = bsc_pkg::LANE_W,
    parameter bit HAS_DEPTH_LOW = 1'b1
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [ADDR_W-1:2] addr_upper,
    input wire logic burst_start_bit0,
    input wire logic burst_start_bit1,
    input wire logic processor_address_strobe_n,
    input wire logic controller_address_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_qualifier_n,
    input wire logic lane_a_write_select_n,
    input wire logic lane_b_write_select_n,
    input wire logic lane_c_write_select_n,
    input wire logic lane_d_write_select_n,
    input wire logic primary_select_n,
    input wire logic depth_select_high,
    input wire logic depth_select_low_n,
    input wire logic output_enable_n,
    input wire logic burst_order_interleaved,
    input wire logic [LANES*LANE_W-1:0] dq_in,
    output logic [LANES*LANE_W-1:0] dq_out,
    output logic dq_oe
);
    localparam int DATA_W = LANES * LANE_W;
    localparam int BW = bsc_pkg::BURST_W;

    // The lane wiring below is written for four lanes only.
    if (LANES != 4 || WORDS > (1 << ADDR_W) || ADDR_W <= BW) begin : g_bad
        $error("Unsupported geometry for bsc_sram_ctrl.");
    end

    // Storage array; it has no reset, like the real cells.
    logic [DATA_W-1:0] mem [WORDS];

    logic selected;
    logic [ADDR_W-1:BW] base;
    logic [BW-1:0] start;
    logic [BW-1:0] cnt;
    logic by_proc;
    logic rd_pending;
    logic [ADDR_W-1:0] rd_addr;
    logic oe_mask;

    // Selection and strobe decode.
    wire depth_low_ok = HAS_DEPTH_LOW ? ~depth_select_low_n : 1'b1; // [R10]
    wire sel_in = ~primary_select_n & depth_select_high & depth_low_ok; // [R9]
    wire proc_take = ~processor_address_strobe_n & ~primary_select_n; // [R8]
    wire ctrl_take = ~controller_address_strobe_n & ~proc_take; // [R13]
    wire strobe = proc_take | ctrl_take;
    wire capture = strobe & sel_in; // [R2]
    wire deselect = strobe & ~sel_in;
    wire advance = ~strobe & selected & ~burst_advance_n; // [R7]

    // Per-lane write enables.
    wire [LANES-1:0] lane_sel_n = {lane_d_write_select_n,
        lane_c_write_select_n, lane_b_write_select_n, lane_a_write_select_n};
    wire [LANES-1:0] lane_wr;
    genvar gi;
    generate
        for (gi = 0; gi < LANES; gi++) begin : g_lane
            // The qualifier gates lane selects; global write overrides.
            assign lane_wr[gi] = ~global_write_n |
                (~byte_write_qualifier_n & ~lane_sel_n[gi]); // [R4] [R5] [R6]
        end
    endgenerate
    wire write_req = |lane_wr;

    // A processor-strobe start is always a read; its write comes later.
    // Advance still runs while the processor strobe is being ignored.
    wire continue_cyc = ~strobe & selected;
    wire write_go = ((capture & ~proc_take) | continue_cyc) & write_req;
    wire read_go = (capture & (proc_take | ~write_req)) |
        (continue_cyc & ~write_req);

    // Next burst state and the word addressed at this edge.
    wire [ADDR_W-1:BW] next_base = capture ? addr_upper : base;
    wire [BW-1:0] next_start = capture ?
        {burst_start_bit1, burst_start_bit0} : start; // [R3]
    wire [BW-1:0] next_cnt = capture ? bsc_pkg::BURST_FIRST :
        (advance ? cnt + bsc_pkg::BURST_STEP : cnt); // [R7] [R15]
    wire [BW-1:0] lin_lsb = next_start + next_cnt;
    wire [BW-1:0] ilv_lsb = next_start ^ next_cnt;
    wire [BW-1:0] burst_lsb =
        (burst_order_interleaved == bsc_pkg::ORDER_INTERLEAVED) ?
        ilv_lsb : lin_lsb; // [R16]
    wire [ADDR_W-1:0] eff_addr = {next_base, burst_lsb}; // [R1]

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            selected <= 1'b0;
            base <= '0;
            start <= bsc_pkg::BURST_FIRST;
            cnt <= bsc_pkg::BURST_FIRST;
            by_proc <= 1'b0;
        end else if (clk_en) begin
            if (capture) begin
                selected <= 1'b1;
            end else if (deselect) begin
                selected <= 1'b0;
            end
            base <= next_base;
            start <= next_start;
            cnt <= next_cnt;
            if (strobe) begin
                by_proc <= proc_take; // [R13]
            end
        end
    end

    // Two-stage read: address at one edge, data out at the next.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_pending <= 1'b0;
            rd_addr <= '0;
            oe_mask <= 1'b0;
            dq_out <= '0;
        end else if (clk_en) begin
            rd_pending <= read_go;
            if (read_go) begin
                rd_addr <= eff_addr; // [R14]
            end
            // The pipe still holds stale data right after a deselect.
            oe_mask <= read_go & capture & ~selected; // [R12]
            if (rd_pending) begin
                dq_out <= mem[rd_addr]; // [R14]
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst_b && clk_en && write_go) begin
            for (int i = 0; i < LANES; i++) begin
                if (lane_wr[i]) begin
                    mem[eff_addr][i*LANE_W +: LANE_W] <=
                        dq_in[i*LANE_W +: LANE_W]; // [R4] [R5]
                end
            end
        end
    end

    // Output enable acts without the clock, as the pin does.
    assign dq_oe = ~output_enable_n & ~oe_mask; // [R11] [R12]

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_b);

    property p_capture;
        clk_en && capture |=> base == $past(addr_upper) &&
            start == {$past(burst_start_bit1), $past(burst_start_bit0)} &&
            cnt == bsc_pkg::BURST_FIRST;
    endproperty
    a_capture: assert property (p_capture) // [R2] [R3]
        else $error("Address not captured on a qualified strobe.");

    property p_proc_ignored;
        clk_en && primary_select_n && !processor_address_strobe_n &&
            controller_address_strobe_n |=> $stable(base) &&
            $stable(start) && $stable(selected);
    endproperty
    a_proc_ignored: assert property (p_proc_ignored) // [R8]
        else $error("Processor strobe acted while primary select high.");

    property p_proc_wins;
        clk_en && !processor_address_strobe_n &&
            !controller_address_strobe_n && !primary_select_n |=> by_proc;
    endproperty
    a_proc_wins: assert property (p_proc_wins) // [R13]
        else $error("Controller strobe won over processor strobe.");

    property p_advance;
        clk_en && selected && processor_address_strobe_n &&
            controller_address_strobe_n && !burst_advance_n
            |=> cnt == $past(cnt) + bsc_pkg::BURST_STEP;
    endproperty
    a_advance: assert property (p_advance) // [R7] [R15]
        else $error("Burst counter did not advance by one.");

    property p_depth_high;
        clk_en && !depth_select_high && capture == 1'b0 && strobe
            |=> !selected;
    endproperty
    a_depth_high: assert property (p_depth_high) // [R9]
        else $error("Device stayed selected with depth select low.");

    property p_global_write;
        !global_write_n |-> lane_wr == {LANES{1'b1}};
    endproperty
    a_global_write: assert property (p_global_write) // [R5]
        else $error("Global write did not enable every lane.");

    property p_no_qualifier;
        global_write_n && byte_write_qualifier_n |-> lane_wr == '0;
    endproperty
    a_no_qualifier: assert property (p_no_qualifier) // [R4]
        else $error("Lane written without byte qualifier.");

    property p_oe_high;
        output_enable_n |-> dq_oe != bsc_pkg::DRIVE_ON;
    endproperty
    a_oe_high: assert property (p_oe_high) // [R11]
        else $error("Data pins driven while output enable high.");

    property p_first_read_masked;
        clk_en && !selected && capture && read_go |=> !dq_oe;
    endproperty
    a_first_read_masked: assert property (p_first_read_masked) // [R12]
        else $error("Outputs driven on first read clock after deselect.");

    property p_read_pipe;
        clk_en && read_go |=> rd_pending && rd_addr == $past(eff_addr);
    endproperty
    a_read_pipe: assert property (p_read_pipe) // [R14]
        else $error("Read address not held for the pipelined output.");
endmodule : bsc_sram_ctrl

// File: common/bsc_pkg.sv
// Shared constants for the burst SRAM control-input block.
package bsc_pkg;
    localparam int ADDR_W = 18;
    localparam int WORDS = 262144;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int BURST_W = 2;
    localparam logic [1:0] BURST_FIRST = 2'h0;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic ORDER_LINEAR = 1'h0;
    localparam logic ORDER_INTERLEAVED = 1'h1;
    localparam logic DRIVE_ON = 1'h1;
endpackage : bsc_pkg

// File: tb/bsc_host_model.sv
// Bus master model that drives the SRAM control, address and data pins.
module bsc_host_model (
    input wire logic sys_clk,
    output logic [14:0] ctl,
    output logic [15:0] addr,
    output logic [35:0] dq
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        ctl = 15'h05ff;
        addr = 16'h0000;
        dq = 36'h0;
    end
    // One bus cycle: change just after the edge, hold until the next one.
    task automatic cyc(input logic [14:0] c, input logic [15:0] a,
                       input logic [35:0] d);
        @(posedge sys_clk);
        #2;
        ctl = c;
        addr = a;
        // Without a write the data lines toggle, so a stray write shows.
        dq = (c[3] & c[4]) ? ~dq : d;
    endtask : cyc
endmodule : bsc_host_model

// File: tb/tb.sv
// Self-checking bench for the burst SRAM control-input block.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [14:0] IDLE = 15'h05ff, P = 15'h0001, C = 15'h0002;
    localparam logic [14:0] V = 15'h0004, G = 15'h0008, B = 15'h0010;
    localparam logic [14:0] LA = 15'h0020, LB = 15'h0040, S1 = 15'h0200;
    localparam logic [14:0] S2 = 15'h0400, OE = 15'h1000;
    localparam logic [14:0] L1 = 15'h2000, L2 = 15'h4000;
    localparam logic [15:0] A = 16'h1234;
    logic sys_clk = 1'b0, rst_b = 1'b0, order = 1'b0, dq_oe;
    logic [14:0] ctl;
    logic [15:0] addr;
    logic [35:0] dq, dq_out;
    logic [35:0] e [4];
    int n_fail = 0, comparisons = 0, cycles = 0;
    always #10 sys_clk = ~sys_clk;
    bsc_host_model host (.sys_clk(sys_clk), .ctl(ctl), .addr(addr), .dq(dq));
    bsc_sram_ctrl dut (
        .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(1'b1), .addr_upper(addr),
        .burst_start_bit0(ctl[13]), .burst_start_bit1(ctl[14]),
        .processor_address_strobe_n(ctl[0]),
        .controller_address_strobe_n(ctl[1]), .burst_advance_n(ctl[2]),
        .global_write_n(ctl[3]), .byte_write_qualifier_n(ctl[4]),
        .lane_a_write_select_n(ctl[5]), .lane_b_write_select_n(ctl[6]),
        .lane_c_write_select_n(ctl[7]), .lane_d_write_select_n(ctl[8]),
        .primary_select_n(ctl[9]), .depth_select_high(ctl[10]),
        .depth_select_low_n(ctl[11]), .output_enable_n(ctl[12]),
        .burst_order_interleaved(order), .dq_in(dq), .dq_out(dq_out),
        .dq_oe(dq_oe)
    );
    task automatic chk(input logic [35:0] s, input logic [35:0] x);
        comparisons++;
        if (s !== x) begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, s, x);
        end
    endtask : chk
    task automatic close_out();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // The write starts at word 3 so the linear burst must wrap to 0.
    task automatic t_burst();
        for (int k = 0; k < 4; k++) e[k] = 36'h9_8765_4320 + 36'(k);
        host.cyc(IDLE ^ C ^ G ^ L1 ^ L2, A, e[3]);
        for (int k = 0; k < 3; k++) host.cyc(IDLE ^ V ^ G, A, e[k]);
        host.cyc(IDLE ^ P ^ C ^ G ^ L1 ^ L2, A, 36'h0);
        // Read data trails its address by one edge, so the first look waits.
        for (int k = 0; k < 5; k++) begin
            host.cyc(k < 3 ? IDLE ^ V : IDLE, A, 36'h0);
            if (k > 0) chk(dq_out, e[2'(2 + k)]);
        end
    endtask : t_burst
    task automatic t_interleave();
        order = 1'b1;
        host.cyc(IDLE ^ P ^ L1, A, 36'h0);
        for (int k = 0; k < 5; k++) begin
            host.cyc(k < 3 ? IDLE ^ V : IDLE, A, 36'h0);
            if (k > 0) chk(dq_out, e[2'(k - 1) ^ 2'h1]);
        end
        order = 1'b0;
    endtask : t_interleave
    task automatic t_bytes();
        host.cyc(IDLE ^ C ^ B ^ LA, A, 36'hf_ffff_ffff);
        host.cyc(IDLE ^ V ^ LB, A, 36'h0);
        e[0][8:0] = 9'h1ff;
        host.cyc(IDLE ^ P, A, 36'h0);
        host.cyc(IDLE ^ V, A, 36'h0);
        chk(dq_out, e[1]);
        host.cyc(IDLE, A, 36'h0);
        chk(dq_out, e[0]);
    endtask : t_bytes
    task automatic t_deselect();
        host.cyc(IDLE ^ C ^ S2, A, 36'h0);
        host.cyc(IDLE ^ P, A, 36'h0);
        host.cyc(IDLE ^ P ^ S1 ^ V, A, 36'h0);
        chk({35'h0, dq_oe}, 36'h0);
        chk(dq_out, e[1]);
        host.cyc(IDLE, A, 36'h0);
        chk({35'h0, dq_oe}, 36'h1);
        chk(dq_out, e[0]);
        // The enable pin is combinational, so it is judged one cycle later.
        host.cyc(IDLE ^ OE, A, 36'h0);
        chk(dq_out, e[1]);
        host.cyc(IDLE ^ OE, A, 36'h0);
        chk({35'h0, dq_oe}, 36'h0);
    endtask : t_deselect
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 1000) begin
            n_fail++;
            close_out();
        end
    end
    initial begin
        repeat (2) @(posedge sys_clk);
        #2 rst_b = 1'b1;
        t_burst();
        t_interleave();
        t_bytes();
        t_deselect();
        close_out();
    end
endmodule : tb
